// [design/isrg_pkg.sv]
// Purpose: Shared constants for the instrument status register groups
// Assumes: Three 16-bit groups, command port with group and register select
// Notes:   Register select codes are local choices
package isrg_pkg;
  localparam int unsigned GRP_W   = 16;
  localparam int unsigned NGRP    = 3;
  // Group select
  localparam logic [1:0] GRP_CALL = 2'h0;
  localparam logic [1:0] GRP_CAL  = 2'h1;
  localparam logic [1:0] GRP_HW2  = 2'h2;
  // Register select
  localparam logic [2:0] SEL_COND = 3'h0;
  localparam logic [2:0] SEL_PTR  = 3'h1;
  localparam logic [2:0] SEL_NTR  = 3'h2;
  localparam logic [2:0] SEL_EVT  = 3'h3;
  localparam logic [2:0] SEL_ENA  = 3'h4;
  // Reset values
  localparam logic [15:0] PTR_RST = 16'h7fff;
  localparam logic [15:0] NTR_RST = 16'h0000;
  localparam logic [15:0] ENA_RST = 16'h0000;
  localparam logic [15:0] EVT_RST = 16'h0000;
  // Bit positions
  localparam int unsigned RSVD_BIT     = 15;
  localparam int unsigned CALL_CONNECT = 5;
  localparam int unsigned CALL_ACCESS  = 4;
  localparam int unsigned CALL_PAGE    = 3;
  localparam int unsigned CALL_REGSTR  = 1;
  localparam int unsigned CALL_ACTIVE  = 0;
  localparam int unsigned CAL_TXZERO   = 4;
  localparam int unsigned CAL_VOLT     = 3;
  localparam int unsigned CAL_CNTR     = 2;
  localparam int unsigned CAL_SAMP     = 1;
  localparam int unsigned CAL_SPEC     = 0;
  localparam int unsigned HW2_ACP_RBW  = 11;
  localparam int unsigned HW2_ACP_WIDE = 10;
  localparam int unsigned HW2_NOTCH    = 9;
  localparam int unsigned HW2_AFG2_V   = 8;
  localparam int unsigned HW2_FMDEV    = 7;
  localparam int unsigned HW2_AMFM     = 6;
  localparam int unsigned HW2_AF_RNG   = 5;
  localparam int unsigned HW2_RF_RNG   = 4;
  localparam int unsigned HW2_RF_TUNE  = 3;
  localparam int unsigned HW2_OFFSET   = 2;
  localparam int unsigned HW2_AMPL     = 1;
  localparam int unsigned HW2_REFLVL   = 0;
endpackage

// [design/isrg_grp_if.sv]
// Purpose: Carrier between the top and one status group
// Assumes: Same clock on both sides
// Notes:   One instance per group
interface isrg_grp_if;
  logic [15:0] cond;
  logic        wr_ptr;
  logic        wr_ntr;
  logic        wr_ena;
  logic        rd_evt;
  logic        clr;
  logic [15:0] wdata;
  logic [15:0] ptr;
  logic [15:0] ntr;
  logic [15:0] evt;
  logic [15:0] ena;
  logic        summary;
  modport top (output cond, wr_ptr, wr_ntr, wr_ena, rd_evt, clr, wdata,
               input ptr, ntr, evt, ena, summary);
  modport grp (input cond, wr_ptr, wr_ntr, wr_ena, rd_evt, clr, wdata,
               output ptr, ntr, evt, ena, summary);
endinterface

// [design/isrg_group.sv]
// Purpose: One status group: filters, event, enable, summary
// Assumes: Condition already synchronised and bit 15 forced low
// Notes:   Set wins over a clear in the same cycle
module isrg_group (
  input  wire logic clk,
  input  wire logic reset_n,
  isrg_grp_if.grp   g
);
  logic [15:0] cond_d_r;
  logic [15:0] ptr_r;
  logic [15:0] ntr_r;
  logic [15:0] evt_r;
  logic [15:0] ena_r;
  logic        sum_r;
  logic [15:0] rise;
  logic [15:0] fall;
  logic [15:0] hit;
  logic [15:0] evt_nxt;

  assign rise    = g.cond & ~cond_d_r;
  assign fall    = ~g.cond & cond_d_r;
  assign hit     = (rise & ptr_r) | (fall & ntr_r);
  assign evt_nxt = ((g.rd_evt | g.clr) ? 16'h0000 : evt_r) | hit;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cond_d_r <= 16'h0000;
      ptr_r    <= isrg_pkg::PTR_RST;
      ntr_r    <= isrg_pkg::NTR_RST;
      evt_r    <= isrg_pkg::EVT_RST;
      ena_r    <= isrg_pkg::ENA_RST;
      sum_r    <= 1'b0;
    end else begin
      cond_d_r <= g.cond;
      if (g.wr_ptr) ptr_r <= g.wdata;
      if (g.wr_ntr) ntr_r <= g.wdata;
      if (g.wr_ena) ena_r <= g.wdata;
      evt_r    <= evt_nxt;
      sum_r    <= |(evt_r & ena_r);
    end
  end

  assign g.ptr     = ptr_r;
  assign g.ntr     = ntr_r;
  assign g.evt     = evt_r;
  assign g.ena     = ena_r;
  assign g.summary = sum_r;
endmodule

// [design/isrg_top.sv]
// Purpose: Three status register groups behind a command port
// Assumes: Status inputs come from other clock domains
// Notes:   Reads answer one cycle after the strobe
module isrg_top (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  input  wire logic        cmd_clear_status,
  input  wire logic [1:0]  cmd_group,
  input  wire logic [2:0]  cmd_reg,
  input  wire logic [15:0] cmd_wdata,
  output logic      [15:0] rd_data,
  output logic             rd_valid,
  input  wire logic        call_connect,
  input  wire logic        call_access,
  input  wire logic        call_page,
  input  wire logic        call_register,
  input  wire logic        call_active,
  input  wire logic        cal_txpwr_zero_fail,
  input  wire logic        cal_voltmeter_fail,
  input  wire logic        cal_counter_fail,
  input  wire logic        cal_sampler_fail,
  input  wire logic        cal_spectrum_fail,
  input  wire logic        hw2_acp_rbw_bad,
  input  wire logic        hw2_acp_too_wide,
  input  wire logic        hw2_notch_range,
  input  wire logic        hw2_audio_generator_two_volt,
  input  wire logic        hw2_fm_dev_large,
  input  wire logic        hw2_am_fm_both,
  input  wire logic        hw2_af_autorange,
  input  wire logic        hw2_rf_autorange,
  input  wire logic        hw2_rf_autotune,
  input  wire logic        hw2_offset_bad,
  input  wire logic        hw2_ampl_high,
  input  wire logic        hw2_reflvl_bad,
  output logic             call_summary,
  output logic             cal_summary,
  output logic             hw2_summary
);
  logic [15:0] raw_call;
  logic [15:0] raw_cal;
  logic [15:0] raw_hw2;
  logic [47:0] sync1_r;
  logic [47:0] sync2_r;
  logic [15:0] rd_data_r;
  logic        rd_valid_r;
  logic [15:0] rd_nxt;
  logic [15:0] sel_word;
  logic        hit_call;
  logic        hit_cal;
  logic        hit_hw2;

  // Condition assembly; unused bits tie low
  always_comb begin
    raw_call = 16'h0000;
    raw_call[isrg_pkg::CALL_CONNECT] = call_connect;
    raw_call[isrg_pkg::CALL_ACCESS]  = call_access;
    raw_call[isrg_pkg::CALL_PAGE]    = call_page;
    raw_call[isrg_pkg::CALL_REGSTR]  = call_register;
    raw_call[isrg_pkg::CALL_ACTIVE]  = call_active;
    raw_cal = 16'h0000;
    raw_cal[isrg_pkg::CAL_TXZERO] = cal_txpwr_zero_fail;
    raw_cal[isrg_pkg::CAL_VOLT]   = cal_voltmeter_fail;
    raw_cal[isrg_pkg::CAL_CNTR]   = cal_counter_fail;
    raw_cal[isrg_pkg::CAL_SAMP]   = cal_sampler_fail;
    raw_cal[isrg_pkg::CAL_SPEC]   = cal_spectrum_fail;
    raw_hw2 = 16'h0000;
    raw_hw2[isrg_pkg::HW2_ACP_RBW]  = hw2_acp_rbw_bad;
    raw_hw2[isrg_pkg::HW2_ACP_WIDE] = hw2_acp_too_wide;
    raw_hw2[isrg_pkg::HW2_NOTCH]    = hw2_notch_range;
    raw_hw2[isrg_pkg::HW2_AFG2_V]   = hw2_audio_generator_two_volt;
    raw_hw2[isrg_pkg::HW2_FMDEV]    = hw2_fm_dev_large;
    raw_hw2[isrg_pkg::HW2_AMFM]     = hw2_am_fm_both;
    raw_hw2[isrg_pkg::HW2_AF_RNG]   = hw2_af_autorange;
    raw_hw2[isrg_pkg::HW2_RF_RNG]   = hw2_rf_autorange;
    raw_hw2[isrg_pkg::HW2_RF_TUNE]  = hw2_rf_autotune;
    raw_hw2[isrg_pkg::HW2_OFFSET]   = hw2_offset_bad;
    raw_hw2[isrg_pkg::HW2_AMPL]     = hw2_ampl_high;
    raw_hw2[isrg_pkg::HW2_REFLVL]   = hw2_reflvl_bad;
  end

  // Status sources are asynchronous; two stages before use
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_r <= 48'h0;
      sync2_r <= 48'h0;
    end else begin
      sync1_r <= {raw_hw2, raw_cal, raw_call};
      sync2_r <= sync1_r;
    end
  end

  isrg_grp_if g_call ();
  isrg_grp_if g_cal ();
  isrg_grp_if g_hw2 ();

  function automatic logic [15:0] cond_mask(input logic [15:0] c);
    logic [15:0] m;
    m = c;
    m[isrg_pkg::RSVD_BIT] = 1'b0;
    return m;
  endfunction

  function automatic logic [15:0] pick(input logic [2:0] r, input logic [15:0] cnd,
                                       input logic [15:0] p, input logic [15:0] n,
                                       input logic [15:0] e, input logic [15:0] en);
    logic [15:0] v;
    v = 16'h0000;
    unique case (r)
      isrg_pkg::SEL_COND: v = cnd;
      isrg_pkg::SEL_PTR:  v = p;
      isrg_pkg::SEL_NTR:  v = n;
      isrg_pkg::SEL_EVT:  v = e;
      isrg_pkg::SEL_ENA:  v = en;
      default:            v = 16'h0000;
    endcase
    return v;
  endfunction

  assign hit_call = (cmd_group == isrg_pkg::GRP_CALL);
  assign hit_cal  = (cmd_group == isrg_pkg::GRP_CAL);
  assign hit_hw2  = (cmd_group == isrg_pkg::GRP_HW2);

  // Identical wiring for each group
  assign g_call.cond   = cond_mask(sync2_r[15:0]);
  assign g_cal.cond    = cond_mask(sync2_r[31:16]);
  assign g_hw2.cond    = cond_mask(sync2_r[47:32]);
  assign g_call.wdata  = cmd_wdata;
  assign g_cal.wdata   = cmd_wdata;
  assign g_hw2.wdata   = cmd_wdata;
  assign g_call.clr    = cmd_clear_status;
  assign g_cal.clr     = cmd_clear_status;
  assign g_hw2.clr     = cmd_clear_status;
  assign g_call.wr_ptr = cmd_wr & hit_call & (cmd_reg == isrg_pkg::SEL_PTR);
  assign g_call.wr_ntr = cmd_wr & hit_call & (cmd_reg == isrg_pkg::SEL_NTR);
  assign g_call.wr_ena = cmd_wr & hit_call & (cmd_reg == isrg_pkg::SEL_ENA);
  assign g_call.rd_evt = cmd_rd & hit_call & (cmd_reg == isrg_pkg::SEL_EVT);
  assign g_cal.wr_ptr  = cmd_wr & hit_cal & (cmd_reg == isrg_pkg::SEL_PTR);
  assign g_cal.wr_ntr  = cmd_wr & hit_cal & (cmd_reg == isrg_pkg::SEL_NTR);
  assign g_cal.wr_ena  = cmd_wr & hit_cal & (cmd_reg == isrg_pkg::SEL_ENA);
  assign g_cal.rd_evt  = cmd_rd & hit_cal & (cmd_reg == isrg_pkg::SEL_EVT);
  assign g_hw2.wr_ptr  = cmd_wr & hit_hw2 & (cmd_reg == isrg_pkg::SEL_PTR);
  assign g_hw2.wr_ntr  = cmd_wr & hit_hw2 & (cmd_reg == isrg_pkg::SEL_NTR);
  assign g_hw2.wr_ena  = cmd_wr & hit_hw2 & (cmd_reg == isrg_pkg::SEL_ENA);
  assign g_hw2.rd_evt  = cmd_rd & hit_hw2 & (cmd_reg == isrg_pkg::SEL_EVT);

  isrg_group u_call (.clk(clk), .reset_n(reset_n), .g(g_call));
  isrg_group u_cal  (.clk(clk), .reset_n(reset_n), .g(g_cal));
  isrg_group u_hw2  (.clk(clk), .reset_n(reset_n), .g(g_hw2));

  // Read returns the event value before its clear takes hold
  assign sel_word = hit_call ? pick(cmd_reg, g_call.cond, g_call.ptr, g_call.ntr,
                                    g_call.evt, g_call.ena) :
                    hit_cal  ? pick(cmd_reg, g_cal.cond, g_cal.ptr, g_cal.ntr,
                                    g_cal.evt, g_cal.ena) :
                    hit_hw2  ? pick(cmd_reg, g_hw2.cond, g_hw2.ptr, g_hw2.ntr,
                                    g_hw2.evt, g_hw2.ena) : 16'h0000;
  assign rd_nxt   = cmd_rd ? sel_word : rd_data_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_data_r  <= 16'h0000;
      rd_valid_r <= 1'b0;
    end else begin
      rd_data_r  <= rd_nxt;
      rd_valid_r <= cmd_rd;
    end
  end

  assign rd_data      = rd_data_r;
  assign rd_valid     = rd_valid_r;
  assign call_summary = g_call.summary;
  assign cal_summary  = g_cal.summary;
  assign hw2_summary  = g_hw2.summary;
endmodule

// [dv/isrg_sva.sv]
// Purpose: Port checks for the status register groups
// Assumes: Commands change just after the rising edge
// Notes:   Event clearing is judged by the bench, not here
module isrg_sva (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        cmd_wr,
  input wire logic        cmd_rd,
  input wire logic [1:0]  cmd_group,
  input wire logic [2:0]  cmd_reg,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] rd_data,
  input wire logic        rd_valid,
  input wire logic        cal_summary
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  wire ena_cal = cmd_group == isrg_pkg::GRP_CAL && cmd_reg == isrg_pkg::SEL_ENA;
  a_rdv_after_rd: assert property (cmd_rd |=> rd_valid)
    else $error("Read answer missing");
  a_rdv_no_spur: assert property (!cmd_rd |=> !rd_valid)
    else $error("Read answer without query");
  // Past reset term: a reset edge may zero the data
  a_data_holds: assert property (!rd_valid && $past(reset_n) |-> $stable(rd_data))
    else $error("Read data moved without a query");
  a_grp_unmapped: assert property (cmd_rd && cmd_group == 2'h3 |=> rd_data == 16'h0000)
    else $error("Unmapped group read not zero");
  a_reg_unmapped: assert property (cmd_rd && cmd_reg > isrg_pkg::SEL_ENA |=> rd_data == 16'h0000)
    else $error("Unmapped register read not zero");
  a_cond_bit15: assert property (cmd_rd && cmd_reg == isrg_pkg::SEL_COND |=> !rd_data[15])
    else $error("Condition bit 15 set");
  a_ena_readback: assert property (cmd_wr && ena_cal ##1 !cmd_wr ##1 cmd_rd && ena_cal
    |=> rd_data == $past(cmd_wdata, 3)) else $error("Enable readback wrong");
  a_ena_zero_sum: assert property (cmd_wr && ena_cal && cmd_wdata == 16'h0000
    |=> ##1 !cal_summary) else $error("Summary set with enable zero");
  c_sum: cover property (cal_summary);
  c_rd_nonzero: cover property (cmd_rd ##1 rd_data != 16'h0000);
  c_ena_rb: cover property (cmd_wr && ena_cal ##1 !cmd_wr ##1 cmd_rd && ena_cal);
endmodule
bind isrg_top isrg_sva u_sva (.clk, .reset_n, .cmd_wr, .cmd_rd, .cmd_group, .cmd_reg,
  .cmd_wdata, .rd_data, .rd_valid, .cal_summary);

// [dv/isrg_ctrl_model.sv]
// Purpose: Remote controller issuing status commands
// Assumes: One command at a time, strobes one cycle long
// Notes:   Idle qualifiers flip so stale values never look valid
module isrg_ctrl_model (
  input  wire logic        clk,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid,
  output logic             cmd_wr,
  output logic             cmd_rd,
  output logic             cmd_clear_status,
  output logic [1:0]       cmd_group,
  output logic [2:0]       cmd_reg,
  output logic [15:0]      cmd_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cmd_wr, cmd_rd, cmd_clear_status, cmd_group, cmd_reg, cmd_wdata} = '0;
  task automatic issue(input logic w, input logic r, input logic c, input logic [1:0] g,
                       input logic [2:0] s, input logic [15:0] d);
    @(posedge clk);
    #2;
    {cmd_wr, cmd_rd, cmd_clear_status, cmd_group, cmd_reg, cmd_wdata} = {w, r, c, g, s, d};
    @(posedge clk);
    #2;
    {cmd_wr, cmd_rd, cmd_clear_status} = 3'h0;
    {cmd_group, cmd_reg, cmd_wdata} = ~{g, s, d};
  endtask
  task automatic query(input logic [1:0] g, input logic [2:0] s, output logic [15:0] q,
                       output logic ok);
    issue(1'b0, 1'b1, 1'b0, g, s, 16'h0000);
    for (int n = 0; n < 4 && rd_valid !== 1'b1; n++) begin
      @(posedge clk);
      #2;
    end
    ok = rd_valid === 1'b1;
    q = rd_data;
  endtask
endmodule

// [dv/tb.sv]
// Purpose: Self-checking bench for the status register groups
// Assumes: Controller model issues every command
// Notes:   Row table covers plain access; events tested by hand
module tb;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
  typedef struct {logic w; logic [1:0] g; logic [2:0] r; logic [15:0] d; logic [15:0] e;} isrg_row_t;
  logic        clk, reset_n, cmd_wr, cmd_rd, cmd_clear_status, rd_valid;
  logic        call_summary, cal_summary, hw2_summary;
  logic [1:0]  cmd_group;
  logic [2:0]  cmd_reg;
  logic [15:0] cmd_wdata, rd_data, d;
  logic [4:0]  callv, calv;
  logic [11:0] hwv;
  int          num_errors, checked;
  // Group 0 call, 1 cal, 2 hw2; reg 0 cond, 1 pos, 2 neg, 3 event, 4 enable
  isrg_row_t rows [13] = '{'{0, 2'h0, 3'h1, 16'h0, 16'h7fff}, '{0, 2'h2, 3'h2, 16'h0, 16'h0},
    '{0, 2'h1, 3'h4, 16'h0, 16'h0}, '{0, 2'h1, 3'h3, 16'h0, 16'h0},
    '{1, 2'h0, 3'h1, 16'ha5a5, 16'ha5a5}, '{1, 2'h1, 3'h2, 16'hffff, 16'hffff},
    '{1, 2'h2, 3'h4, 16'h8001, 16'h8001}, '{1, 2'h0, 3'h4, 16'h0001, 16'h0001},
    '{1, 2'h1, 3'h4, 16'h00ff, 16'h00ff}, '{1, 2'h1, 3'h4, 16'h0, 16'h0},
    '{1, 2'h1, 3'h0, 16'h1234, 16'h0}, '{1, 2'h3, 3'h4, 16'h5555, 16'h0},
    '{1, 2'h0, 3'h5, 16'h5555, 16'h0}};
  isrg_top u_dut (.clk, .reset_n, .cmd_wr, .cmd_rd, .cmd_clear_status, .cmd_group, .cmd_reg,
    .cmd_wdata, .rd_data, .rd_valid, .call_connect(callv[4]), .call_access(callv[3]),
    .call_page(callv[2]), .call_register(callv[1]), .call_active(callv[0]),
    .cal_txpwr_zero_fail(calv[4]), .cal_voltmeter_fail(calv[3]), .cal_counter_fail(calv[2]),
    .cal_sampler_fail(calv[1]), .cal_spectrum_fail(calv[0]), .hw2_acp_rbw_bad(hwv[11]),
    .hw2_acp_too_wide(hwv[10]), .hw2_notch_range(hwv[9]), .hw2_audio_generator_two_volt(hwv[8]),
    .hw2_fm_dev_large(hwv[7]), .hw2_am_fm_both(hwv[6]), .hw2_af_autorange(hwv[5]),
    .hw2_rf_autorange(hwv[4]), .hw2_rf_autotune(hwv[3]), .hw2_offset_bad(hwv[2]),
    .hw2_ampl_high(hwv[1]), .hw2_reflvl_bad(hwv[0]), .call_summary, .cal_summary, .hw2_summary);
  isrg_ctrl_model u_ctrl (.clk, .rd_data, .rd_valid, .cmd_wr, .cmd_rd, .cmd_clear_status,
    .cmd_group, .cmd_reg, .cmd_wdata);
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic summarize;
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Settle past the edge so flags are read after their update
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic rd(input logic [1:0] g, input logic [2:0] r, output logic [15:0] q);
    logic ok;
    u_ctrl.query(g, r, q, ok);
    if (!ok) begin
      num_errors++;
      summarize();
    end
  endtask
  initial begin
    {reset_n, callv, calv, hwv, num_errors, checked} = '0;
    wt(20);
    reset_n = 1;
    foreach (rows[k]) begin
      if (rows[k].w) u_ctrl.issue(1'b1, 1'b0, 1'b0, rows[k].g, rows[k].r, rows[k].d);
      rd(rows[k].g, rows[k].r, d);
      `CHK(d, rows[k].e)
    end
    // Walk one status input at a time so swapped bits show
    for (int i = 0; i < 12; i++) begin
      hwv = 12'h001 << i;
      wt(4);
      rd(2'h2, 3'h0, d);
      `CHK(d, 16'h0001 << i)
    end
    hwv = 12'h000;
    `CHK(hw2_summary, 1'b1)
    callv = 5'h1f;
    calv = 5'h1f;
    wt(5);
    `CHK(call_summary, 1'b1)
    rd(2'h0, 3'h0, d);
    `CHK(d, 16'h003b)
    rd(2'h1, 3'h0, d);
    `CHK(d, 16'h001f)
    rd(2'h0, 3'h3, d);
    `CHK(d, 16'h0021)
    rd(2'h1, 3'h3, d);
    `CHK(d, 16'h001f)
    rd(2'h1, 3'h3, d);
    `CHK(d, 16'h0000)
    u_ctrl.issue(1'b1, 1'b0, 1'b0, 2'h1, 3'h4, 16'h0010);
    calv = 5'h00;
    wt(5);
    `CHK(cal_summary, 1'b1)
    u_ctrl.issue(1'b0, 1'b0, 1'b1, 2'h0, 3'h0, 16'h0000);
    wt(1);
    `CHK({call_summary, cal_summary, hw2_summary}, 3'h0)
    rd(2'h1, 3'h3, d);
    `CHK(d, 16'h0000)
    reset_n = 0;
    wt(3);
    reset_n = 1;
    rd(2'h1, 3'h1, d);
    `CHK(d, 16'h7fff)
    `CHK(cal_summary, 1'b0)
    summarize();
  end
endmodule
